// File: hdl/dsps_ctrl.sv
// Purpose: serial control interpreter of a dual-slot card supply switch, with apb status view
// Assumes: serial pins and fault inputs are asynchronous; sclk is slow next to clk (64 ns period)
// Notes:   the register bus observes, masks and clears events and can force reset; supply levels come from the serial word and mode pin
//
// Notes on behaviour
// RQ1: controller drives serial data, serial clock and latch; device sends nothing back.
// RQ2: one data bit is shifted in on every serial clock rising edge.
// RQ3: latch rising edge copies the 11-bit shifted word into the output word.
// RQ4: controller raises latch after the last bit, before the next clock edge.
// RQ5: either reset input grounds all supply outputs, all other switches open.
// RQ6: outputs stay grounded after reset until a fresh word is latched.
// RQ7: latch strobes are ignored while reset is asserted.
// RQ8: power-up reset grounds all outputs before any word is latched.
// RQ9: one flag output reports overcurrent or overtemperature on any output.
// RQ10: independent mode program supply decode per slot, select bit picks 3.3/5 v.
// RQ11: main supply decode per slot: 0 v, 3.3 v, 5 v, 0 v.
// RQ12: shutdown bit low puts every supply output in high impedance.
// RQ13: mode low selects dependent program supplies, high selects independent.
// RQ14: overcurrent flag is active low.
// RQ15: output word holds between latches whatever the shift register does.
// RQ16: bit order is a parameter; default first bit shifted lands in d10.
//
// Chosen here: the placing of the registers and the APB slave port.

module dsps_ctrl
  import dsps_pkg::*;
#(
  parameter bit FIRST_BIT_D10 = 1'b1
)
(
  // clock and reset
  clk,
  arst_n,
  clk_en,
  // apb slave
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  pready,
  prdata,
  pslverr,
  irq,
  // serial link from controller
  ser_data,
  ser_clk,
  ser_latch,
  // reset and mode pins
  reset_hi,
  reset_in_n,
  mode_indep,
  // analog fault sense, one bit per supply output
  fault_in,
  // supply switch controls
  slot_a_main_supply,
  slot_b_main_supply,
  slot_a_program_supply,
  slot_b_program_supply,
  overcurrent_flag_n
);

  input  wire logic               clk;
  input  wire logic               arst_n;
  input  wire logic               clk_en;
  input  wire logic               psel;
  input  wire logic               penable;
  input  wire logic               pwrite;
  input  wire logic [7:0]         paddr;
  input  wire logic [31:0]        pwdata;
  output      logic               pready;
  output      logic [31:0]        prdata;
  output      logic               pslverr;
  output      logic               irq;
  input  wire logic               ser_data;
  input  wire logic               ser_clk;
  input  wire logic               ser_latch;
  input  wire logic               reset_hi;
  input  wire logic               reset_in_n;
  input  wire logic               mode_indep;
  input  wire logic [FAULT_W-1:0] fault_in;
  output      dsps_sup_t          slot_a_main_supply;
  output      dsps_sup_t          slot_b_main_supply;
  output      dsps_sup_t          slot_a_program_supply;
  output      dsps_sup_t          slot_b_program_supply;
  output      logic               overcurrent_flag_n;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] word;
    logic              loaded;
    logic              sclk_q;
    logic              latch_q;
    logic              oc_q;
    logic              rst_q;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic [0:0]        ctrl;
    logic              rdy;
    logic [31:0]       rdata;
    logic              err;
    dsps_sup_t         a_main;
    dsps_sup_t         b_main;
    dsps_sup_t         a_prog;
    dsps_sup_t         b_prog;
    logic              oc_n;
    logic              irq;
  } dsps_st_t;

  dsps_st_t st_r;
  dsps_st_t st_nxt;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_lvl;

  assign pin_raw = {fault_in, mode_indep, reset_in_n, reset_hi, ser_latch, ser_clk, ser_data}; // RQ1

  dsps_sync #(
    .W   (PIN_W),
    .RST (PIN_RST)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .pin_in (pin_raw),
    .level  (pin_lvl)
  );

  logic              sdata;
  logic              sclk_rise;
  logic              latch_rise;
  logic              rst_active;
  logic              fault_any;
  logic              oc_rise;

  assign sdata      = pin_lvl[P_SDATA];
  assign sclk_rise  = pin_lvl[P_SCLK] & ~st_r.sclk_q;
  assign latch_rise = pin_lvl[P_LATCH] & ~st_r.latch_q;
  // reset_in_n syncs to 0 at power-up, so power-up looks like an asserted reset
  assign rst_active = pin_lvl[P_RESET_HI] | ~pin_lvl[P_RESET_N] | st_r.ctrl[C_SOFT_RST]; // RQ5 RQ8
  assign fault_any  = |pin_lvl[P_FAULT +: FAULT_W]; // RQ9
  assign oc_rise    = fault_any & ~st_r.oc_q;

  // ----------------------------------------------------------------
  // decode of the held word
  // ----------------------------------------------------------------
  dsps_sup_t main_sel [2];
  dsps_sup_t prog_sel [2];

  dsps_decode u_dec (
    .word       (st_r.word),
    .indep_mode (pin_lvl[P_MODE]), // RQ13
    .grounded   (rst_active | ~st_r.loaded), // RQ6
    .main_sel   (main_sel),
    .prog_sel   (prog_sel)
  );

  // ----------------------------------------------------------------
  // apb helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_WORD) || (a == OFS_OUTS);
  endfunction

  logic            acc;
  logic            wr;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [31:0]     rd_mux;

  // answer one cycle into the access phase so read data comes from a flop
  assign acc    = psel & penable & st_r.rdy;
  assign wr     = acc & pwrite & mapped(paddr);
  assign ev_clr = (wr && paddr == OFS_STATUS) ? pwdata[EV_W-1:0] : '0;

  always_comb
  begin
    rd_mux = 32'h0;
    case (paddr)
      OFS_CTRL:   rd_mux[0] = st_r.ctrl[C_SOFT_RST];
      OFS_STATUS: rd_mux[EV_W-1:0] = st_r.status;
      OFS_MASK:   rd_mux[EV_W-1:0] = st_r.mask;
      OFS_WORD:
      begin
        rd_mux[WORD_W-1:0] = st_r.word;
        rd_mux[WORD_SHIFT_LSB +: WORD_W] = st_r.shift;
      end
      OFS_OUTS:
      begin
        rd_mux[4:0]   = st_r.a_main;
        rd_mux[9:5]   = st_r.b_main;
        rd_mux[14:10] = st_r.a_prog;
        rd_mux[19:15] = st_r.b_prog;
        rd_mux[OUTS_LOADED] = st_r.loaded;
        rd_mux[OUTS_RESET]  = rst_active;
        rd_mux[OUTS_MODE]   = pin_lvl[P_MODE];
        rd_mux[OUTS_OC_N]   = st_r.oc_n;
      end
      default:    rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    ev_set = '0;
    if (clk_en)
    begin
      st_nxt.sclk_q  = pin_lvl[P_SCLK];
      st_nxt.latch_q = pin_lvl[P_LATCH];
      st_nxt.oc_q    = fault_any;
      st_nxt.rst_q   = rst_active;

      // shift register runs on its own, even in reset
      if (sclk_rise) // RQ2
      begin
        if (FIRST_BIT_D10) // RQ16
          st_nxt.shift = {st_r.shift[WORD_W-2:0], sdata};
        else
          st_nxt.shift = {sdata, st_r.shift[WORD_W-1:1]};
      end

      // word only moves on an accepted latch edge
      if (rst_active) // RQ6
      begin
        st_nxt.loaded = 1'b0;
        ev_set[EV_LATCH_IGN] = latch_rise; // RQ7
      end
      else if (latch_rise) // RQ3 RQ15
      begin
        st_nxt.word   = st_r.shift;
        st_nxt.loaded = 1'b1;
        ev_set[EV_LATCHED] = 1'b1;
      end

      ev_set[EV_OC]    = oc_rise;
      ev_set[EV_RESET] = rst_active & ~st_r.rst_q;

      // switch controls are registered from the decode
      st_nxt.a_main = main_sel[0];
      st_nxt.b_main = main_sel[1];
      st_nxt.a_prog = prog_sel[0];
      st_nxt.b_prog = prog_sel[1];
      st_nxt.oc_n   = ~fault_any; // RQ9 RQ14

      // apb
      st_nxt.rdy = psel & penable & ~st_r.rdy;
      if (psel & penable & ~st_r.rdy)
      begin
        st_nxt.rdata = pwrite ? 32'h0 : rd_mux;
        st_nxt.err   = ~mapped(paddr);
      end
      if (wr && paddr == OFS_CTRL)
        st_nxt.ctrl[C_SOFT_RST] = pwdata[C_SOFT_RST];
      if (wr && paddr == OFS_MASK)
        st_nxt.mask = pwdata[EV_W-1:0];

      // an event in the same cycle as its clear survives
      st_nxt.status = (st_r.status & ~ev_clr) | ev_set;
      st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r         <= '0; // RQ8
      st_r.mask    <= MASK_RST;
      st_r.ctrl    <= CTRL_RST;
      st_r.a_main  <= SUP_GND;
      st_r.b_main  <= SUP_GND;
      st_r.a_prog  <= SUP_GND;
      st_r.b_prog  <= SUP_GND;
      st_r.oc_n    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready                = penable & st_r.rdy;
  assign prdata                = st_r.rdata;
  assign pslverr               = penable & st_r.rdy & st_r.err;
  assign irq                   = st_r.irq;
  assign slot_a_main_supply    = st_r.a_main;
  assign slot_b_main_supply    = st_r.b_main;
  assign slot_a_program_supply = st_r.a_prog;
  assign slot_b_program_supply = st_r.b_prog;
  assign overcurrent_flag_n    = st_r.oc_n;

endmodule

// File: hdl/dsps_pkg.sv
// Purpose: shared constants and types for the dual-slot supply switch serial control
// Assumes: 32-bit apb, 125 mhz system clock
// Notes:   supply selections are one-hot so a stuck or double selection is easy to see

package dsps_pkg;

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int WORD_W        = 11;
  localparam int B_A_PROG_HI   = 0;
  localparam int B_A_PROG_LO   = 1;
  localparam int B_A_MAIN_LO   = 2;
  localparam int B_A_MAIN_HI   = 3;
  localparam int B_B_PROG_HI   = 4;
  localparam int B_B_PROG_LO   = 5;
  localparam int B_B_MAIN_HI   = 6;
  localparam int B_B_MAIN_LO   = 7;
  localparam int B_SHUTDOWN_CONTROL_BIT_N      = 8;
  localparam int B_A_PROG_SEL  = 9;
  localparam int B_B_PROG_SEL  = 10;

  // ----------------------------------------------------------------
  // supply selection, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0]
  {
    SUP_HIZ = 5'h01,
    SUP_GND = 5'h02,
    SUP_V33 = 5'h04,
    SUP_V50 = 5'h08,
    SUP_V12 = 5'h10
  } dsps_sup_t;

  // ----------------------------------------------------------------
  // pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int PIN_W         = 10;
  localparam int P_SDATA       = 0;
  localparam int P_SCLK        = 1;
  localparam int P_LATCH       = 2;
  localparam int P_RESET_HI    = 3;
  localparam int P_RESET_N     = 4;
  localparam int P_MODE        = 5;
  localparam int P_FAULT       = 6;
  localparam int FAULT_W       = 4;
  localparam logic [9:0] PIN_RST = 10'h000;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_WORD   = 8'h0c;
  localparam logic [7:0] OFS_OUTS   = 8'h10;

  localparam int C_SOFT_RST    = 0;
  localparam int EV_W          = 4;
  localparam int EV_LATCHED    = 0;
  localparam int EV_OC         = 1;
  localparam int EV_LATCH_IGN  = 2;
  localparam int EV_RESET      = 3;
  localparam int WORD_SHIFT_LSB = 16;
  localparam int OUTS_LOADED   = 20;
  localparam int OUTS_RESET    = 21;
  localparam int OUTS_MODE     = 22;
  localparam int OUTS_OC_N     = 23;

  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam logic [0:0]      CTRL_RST = 1'h0;

endpackage

// File: hdl/dsps_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   a change counts only once stages two and three agree

module dsps_sync
  import dsps_pkg::*;
#(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          clk_en,
  // pins and filtered levels
  input  wire logic [W-1:0]  pin_in,
  output      logic [W-1:0]  level
);

  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } dsps_sync_st_t;

  dsps_sync_st_t st_r;
  dsps_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (clk_en)
    begin
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // first stage is never looked at here
      st_nxt.filt = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.filt);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_r <= {RST, RST, RST, RST};
    else
      st_r <= st_nxt;
  end

  assign level = st_r.filt;

endmodule

// File: hdl/dsps_decode.sv
// Purpose: control word to per-slot supply selection
// Assumes: word is the held output word
// Notes:   purely combinational, the caller registers the result

module dsps_decode
  import dsps_pkg::*;
(
  // held word and mode
  input  wire logic [WORD_W-1:0] word,
  input  wire logic              indep_mode,
  input  wire logic              grounded,
  // selections, index 0 is slot a
  output      dsps_sup_t         main_sel [2],
  output      dsps_sup_t         prog_sel [2]
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic dsps_sup_t main_dec(input logic shutdown_control_bit_n, input logic [1:0] pair);
    dsps_sup_t r;
    r = SUP_GND;
    if (!shutdown_control_bit_n)
      r = SUP_HIZ; // RQ12
    else
      case (pair) // RQ11
        2'h1:    r = SUP_V33;
        2'h2:    r = SUP_V50;
        default: r = SUP_GND;
      endcase
    return r;
  endfunction

  function automatic dsps_sup_t prog_dec(input logic shutdown_control_bit_n, input logic [1:0] pair, input logic sel,
                                         input logic indep, input dsps_sup_t main);
    dsps_sup_t r;
    r = SUP_GND;
    if (!shutdown_control_bit_n)
      r = SUP_HIZ; // RQ12
    else
      case (pair) // RQ10
        2'h0:    r = SUP_GND;
        2'h1:    r = indep ? (sel ? SUP_V50 : SUP_V33) : main; // RQ13
        2'h2:    r = SUP_V12;
        default: r = SUP_HIZ;
      endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // per-slot decode
  // ----------------------------------------------------------------
  logic [1:0] main_pair [2];
  logic [1:0] prog_pair [2];
  logic       prog_sel_bit [2];

  assign main_pair[0]    = {word[B_A_MAIN_HI], word[B_A_MAIN_LO]};
  assign main_pair[1]    = {word[B_B_MAIN_HI], word[B_B_MAIN_LO]};
  assign prog_pair[0]    = {word[B_A_PROG_HI], word[B_A_PROG_LO]};
  assign prog_pair[1]    = {word[B_B_PROG_HI], word[B_B_PROG_LO]};
  assign prog_sel_bit[0] = word[B_A_PROG_SEL];
  assign prog_sel_bit[1] = word[B_B_PROG_SEL];

  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_slot
      dsps_sup_t m;
      assign m           = main_dec(word[B_SHUTDOWN_CONTROL_BIT_N], main_pair[s]);
      // grounded wins over shutdown: reset must discharge the card
      assign main_sel[s] = grounded ? SUP_GND : m; // RQ5
      assign prog_sel[s] = grounded ? SUP_GND :
                           prog_dec(word[B_SHUTDOWN_CONTROL_BIT_N], prog_pair[s], prog_sel_bit[s], indep_mode, m); // RQ5
    end
  endgenerate

endmodule

// File: bench/dsps_ctrl_chk.sv
// Purpose: port checker for the serial supply switch control
// Assumes: clk_en only drops while the apb is idle, so apb answers after one wait state
// Notes:   output change window of 12 clk covers sync and decode latency
module dsps_ctrl_chk
  import dsps_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         arst_n,
  // apb
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic         pready,
  input wire logic         pslverr,
  // pins
  input wire logic         ser_latch,
  input wire logic         reset_hi,
  input wire logic         reset_in_n,
  input wire logic         mode_indep,
  input wire logic [3:0]   fault_in,
  input wire dsps_sup_t    slot_a_main_supply,
  input wire dsps_sup_t    slot_b_main_supply,
  input wire dsps_sup_t    slot_a_program_supply,
  input wire dsps_sup_t    slot_b_program_supply,
  input wire logic         overcurrent_flag_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // -----------------------------------------------------------
  // cycles since a pin or an apb write that may move the outputs changed
  // -----------------------------------------------------------
  logic [4:0] pin_r;
  logic [4:0] pin_now;
  logic [7:0] since_r;
  logic [7:0] since_nxt;
  logic       all_gnd;
  assign all_gnd = slot_a_main_supply == SUP_GND && slot_b_main_supply == SUP_GND
                && slot_a_program_supply == SUP_GND && slot_b_program_supply == SUP_GND;
  // soft reset reaches the outputs through a completed apb write
  assign pin_now = {psel & penable & pready & pwrite, ser_latch, mode_indep, reset_hi, reset_in_n};
  always_comb
  begin
    since_nxt = (since_r == 8'hff) ? since_r : since_r + 8'h01;
    if (pin_r != pin_now)
      since_nxt = 8'h00;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_r   <= 5'h01;
      since_r <= 8'h00;
    end
    else
    begin
      pin_r   <= pin_now;
      since_r <= since_nxt;
    end
  end
  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  AST_RST_HI: assert property (reset_hi [*8] |-> all_gnd)
    else $error("supplies not grounded under active high reset");
  AST_RST_LO: assert property (!reset_in_n [*8] |-> all_gnd)
    else $error("supplies not grounded under active low reset");
  AST_AFTER_RST: assert property ($fell(reset_hi) && reset_in_n |=> all_gnd [*8])
    else $error("supplies left ground right after reset");
  AST_HOLD_MAIN: assert property ($changed({slot_a_main_supply, slot_b_main_supply}) |-> since_r <= 8'd12)
    else $error("main supply moved without a latch");
  AST_HOLD_PROG: assert property ($changed({slot_a_program_supply, slot_b_program_supply}) |-> since_r <= 8'd12)
    else $error("program supply moved without a latch");
  AST_OC_ON: assert property ((fault_in != 4'h0) [*8] |-> !overcurrent_flag_n)
    else $error("fault not flagged");
  AST_OC_OFF: assert property ((fault_in == 4'h0) [*8] |-> overcurrent_flag_n)
    else $error("flag low with no fault");
  AST_MAIN_CODE: assert property ($onehot(slot_a_main_supply) && slot_a_main_supply != SUP_V12
                                  && $onehot(slot_b_main_supply) && slot_b_main_supply != SUP_V12)
    else $error("illegal main supply code");
  AST_PREADY: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  cover property ($rose(ser_latch) ##[1:12] slot_a_main_supply == SUP_V50);
  cover property (slot_b_program_supply == SUP_V12);
  cover property (!overcurrent_flag_n);
endmodule

bind dsps_ctrl dsps_ctrl_chk u_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .ser_latch(ser_latch), .reset_hi(reset_hi), .pwrite(pwrite),
  .reset_in_n(reset_in_n), .mode_indep(mode_indep), .fault_in(fault_in),
  .slot_a_main_supply(slot_a_main_supply), .slot_b_main_supply(slot_b_main_supply),
  .slot_a_program_supply(slot_a_program_supply), .slot_b_program_supply(slot_b_program_supply),
  .overcurrent_flag_n(overcurrent_flag_n));

// File: bench/dsps_link_ctl.sv
// Purpose: card-slot controller model on the serial control lines
// Assumes: link period 64 ns, phase free of clk
// Notes:   clock rests low between frames; data shows the inverse after a frame
module dsps_link_ctl
(
  // serial control lines
  output logic ser_data,
  output logic ser_clk,
  output logic ser_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ser_data  = 1'b0;
    ser_clk   = 1'b0;
    ser_latch = 1'b0;
  end
  // first bit sent is d10; n below 11 leaves a partial frame
  task automatic send(input logic [10:0] w, input int n, input bit ltch);
    int i;
    #3;
    for (i = 10; i > 10 - n; i--)
    begin
      ser_data = w[i];
      #32 ser_clk = 1'b1;
      #32 ser_clk = 1'b0;
    end
    if (ltch)
    begin
      #16 ser_latch = 1'b1;
      #64 ser_latch = 1'b0;
    end
    #16 ser_data = ~ser_data;
  endtask
endmodule

// File: bench/dsps_ctrl_test.sv
// Purpose: self-checking bench for the serial supply switch control
// Assumes: default bit order
// Notes:   expectations queue up; watcher processes pop and compare
module dsps_ctrl_test;
  import dsps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, clk_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ser_data, ser_clk, ser_latch, reset_hi, reset_in_n, mode_indep, oc_n;
  logic [3:0]  fault_in;
  dsps_sup_t   am, bm, ap, bp;
  logic [32:0] rq[$];
  logic [21:0] pq[$];
  logic [10:0] cw;
  logic        cm;
  int          fail_count, n_checks, i, p;
  event        pin_ev;
  dsps_link_ctl ctl (.ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch));
  dsps_ctrl DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .ser_data(ser_data), .ser_clk(ser_clk), .ser_latch(ser_latch),
    .reset_hi(reset_hi), .reset_in_n(reset_in_n), .mode_indep(mode_indep), .fault_in(fault_in),
    .slot_a_main_supply(am), .slot_b_main_supply(bm), .slot_a_program_supply(ap),
    .slot_b_program_supply(bp), .overcurrent_flag_n(oc_n));
  always #4 clk = ~clk;
  // -----------------------------------------------------------
  // expectation and compare
  // -----------------------------------------------------------
  function automatic logic [21:0] exp_pins(logic [10:0] w, logic ind, logic rst, logic iq, logic oc);
    dsps_sup_t  m[2], q[2];
    logic [1:0] mp[2], pp[2];
    logic       sel[2];
    int         k;
    mp = '{{w[B_A_MAIN_HI], w[B_A_MAIN_LO]}, {w[B_B_MAIN_HI], w[B_B_MAIN_LO]}};
    pp = '{{w[B_A_PROG_HI], w[B_A_PROG_LO]}, {w[B_B_PROG_HI], w[B_B_PROG_LO]}};
    sel = '{w[B_A_PROG_SEL], w[B_B_PROG_SEL]};
    for (k = 0; k < 2; k++)
    begin
      m[k] = (mp[k] == 2'b01) ? SUP_V33 : (mp[k] == 2'b10) ? SUP_V50 : SUP_GND;
      q[k] = (pp[k] == 2'b00) ? SUP_GND : (pp[k] == 2'b10) ? SUP_V12 : (pp[k] == 2'b11) ? SUP_HIZ
           : ind ? (sel[k] ? SUP_V50 : SUP_V33) : m[k];
      if (!w[B_SHUTDOWN_CONTROL_BIT_N])
        {m[k], q[k]} = {SUP_HIZ, SUP_HIZ};
      if (rst)
        {m[k], q[k]} = {SUP_GND, SUP_GND};
    end
    return {iq, oc, q[1], q[0], m[1], m[0]};
  endfunction
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic expect_pins(input logic [21:0] v);
    pq.push_back(v);
    ->pin_ev;
  endtask
  always @(pin_ev) chk(33'(pq.pop_front()), 33'({irq, oc_n, bp, ap, bm, am}));
  always @(posedge clk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      chk(rq.pop_front(), {pslverr, prdata});
  // -----------------------------------------------------------
  // apb master
  // -----------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic frame(input logic [10:0] w);
    ctl.send(w, 11, 1'b1);
    repeat (12) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400us;
    fail_count++;
    give_verdict();
  end
  // -----------------------------------------------------------
  // tests
  // -----------------------------------------------------------
  initial
  begin
    {clk, arst_n, psel, penable, pwrite, paddr, pwdata, reset_hi, mode_indep, fault_in} = '0;
    {reset_in_n, clk_en} = 2'b11;
    void'($urandom(32'ha13534e8));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    expect_pins(exp_pins(11'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    rd(OFS_MASK, 33'h0);
    rd(OFS_CTRL, 33'h0);
    rd(8'h40, 33'h1_0000_0000);
    $display("test power-up done");
    for (i = 0; i < 24; i++)
    begin
      cw = 11'($urandom);
      cm = 1'($urandom);
      mode_indep <= cm;
      repeat (8) @(posedge clk);
      frame(cw);
      expect_pins(exp_pins(cw, cm, 1'b0, 1'b0, 1'b1));
    end
    ctl.send(~cw, 5, 1'b0);
    repeat (12) @(posedge clk);
    expect_pins(exp_pins(cw, cm, 1'b0, 1'b0, 1'b1));
    clk_en <= 1'b0;
    frame(~cw);
    clk_en <= 1'b1;
    repeat (8) @(posedge clk);
    expect_pins(exp_pins(cw, cm, 1'b0, 1'b0, 1'b1));
    $display("test decode done");
    for (p = 0; p < 2; p++)
    begin
      if (p == 0)
        reset_hi <= 1'b1;
      else
        reset_in_n <= 1'b0;
      repeat (8) @(posedge clk);
      frame(11'h1ff);
      expect_pins(exp_pins(cw, cm, 1'b1, 1'b0, 1'b1));
      reset_hi   <= 1'b0;
      reset_in_n <= 1'b1;
      repeat (20) @(posedge clk);
      expect_pins(exp_pins(cw, cm, 1'b1, 1'b0, 1'b1));
      cw = 11'($urandom) | 11'h100;
      frame(cw);
      expect_pins(exp_pins(cw, cm, 1'b0, 1'b0, 1'b1));
    end
    rd(OFS_STATUS, 33'hd);
    apb(1'b1, OFS_STATUS, 32'hf);
    rd(OFS_STATUS, 33'h0);
    rd(OFS_WORD, {6'h0, cw, 5'h0, cw});
    $display("test reset pins done");
    apb(1'b1, OFS_MASK, 32'h2);
    fault_in <= 4'($urandom | 1);
    repeat (10) @(posedge clk);
    expect_pins(exp_pins(cw, cm, 1'b0, 1'b1, 1'b0));
    rd(OFS_OUTS, {9'h0, 1'b0, cm, 2'b01, 20'(exp_pins(cw, cm, 1'b0, 1'b0, 1'b0))});
    rd(OFS_STATUS, 33'h2);
    fault_in <= 4'h0;
    repeat (10) @(posedge clk);
    expect_pins(exp_pins(cw, cm, 1'b0, 1'b1, 1'b1));
    apb(1'b1, OFS_STATUS, 32'h2);
    apb(1'b1, OFS_MASK, 32'h0);
    fault_in <= 4'h8;
    repeat (10) @(posedge clk);
    expect_pins(exp_pins(cw, cm, 1'b0, 1'b0, 1'b0));
    fault_in <= 4'h0;
    repeat (10) @(posedge clk);
    $display("test fault done");
    apb(1'b1, OFS_CTRL, 32'h1);
    frame(cw);
    expect_pins(exp_pins(cw, cm, 1'b1, 1'b0, 1'b1));
    rd(OFS_CTRL, 33'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    expect_pins(exp_pins(cw, cm, 1'b1, 1'b0, 1'b1));
    rd(OFS_STATUS, 33'he);
    $display("test soft reset done");
    give_verdict();
  end
endmodule
